// File: core/sprite_regs_pkg.sv
// sprite plane geometry and colour-key register bank: offsets, fields, resets
// assumes a 32-bit byte-addressed register port on the display clock
`default_nettype none
package sprite_regs_pkg;
  localparam logic [19:0] off_size = 20'h72190;
  localparam logic [19:0] off_key_value = 20'h72194;
  localparam logic [19:0] off_key_mask = 20'h72198;
  localparam logic [19:0] off_surface_base = 20'h7219c;
  localparam logic [19:0] off_key_max = 20'h721a0;
  localparam logic [19:0] off_tiled_pan = 20'h721a4;
  localparam logic [31:0] size_mask = 32'h0fff0fff;
  localparam logic [31:0] key_value_mask = 32'h00ffffff;
  localparam logic [31:0] key_mask_mask = 32'h07ffffff;
  localparam logic [31:0] surface_mask = 32'hfffff000;
  localparam logic [31:0] key_max_mask = 32'h00ffffff;
  localparam logic [31:0] tiled_pan_mask = 32'h0fff0fff;
  localparam logic [31:0] reg_reset = 32'h00000000;
  localparam int height_lsb = 16;
  localparam int width_lsb = 0;
  localparam int src_en_lsb = 24;
  localparam int chan_hi_lsb = 16;
  localparam int chan_mid_lsb = 8;
  localparam int chan_lo_lsb = 0;
  localparam int surface_lsb = 12;
  typedef enum logic [1:0] {
    arm_idle = 2'b00,
    arm_armed = 2'b01
  } arm_state_t;
endpackage
`default_nettype wire

// File: core/sprite_plane_geometry_key_regs.sv
// sprite plane double-buffered geometry and colour-key register bank
// assumes register writes, vblank and disable inputs all sync to clk_in
`default_nettype none
module sprite_plane_geometry_key_regs
  import sprite_regs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [19:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  input wire logic flip_valid_in,
  input wire logic [31:0] flip_surface_in,
  input wire logic vblank_start_in,
  input wire logic pipe_enable_in,
  input wire logic sprite_enable_in,
  input wire logic key_src_enable_in,
  input wire logic key_dst_enable_in,
  input wire logic tiled_surface_in,
  input wire logic rotate_180_in,
  input wire logic [31:0] linear_pan_in,
  input wire logic [23:0] src_pixel_in,
  input wire logic [23:0] dst_pixel_in,
  output logic [11:0] height_lines_out,
  output logic [11:0] width_pixels_out,
  output logic [31:0] surface_addr_out,
  output logic [31:0] pan_linear_out,
  output logic [11:0] pan_y_out,
  output logic [11:0] pan_x_out,
  output logic pan_lower_right_out,
  output logic key_hit_out,
  output logic size_armed_out
);

  function automatic logic chan_in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    chan_in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic hits(input logic [19:0] a, input logic [19:0] off, input logic stb);
    hits = stb && (a == off);
  endfunction

  logic [31:0] size_r, key_value_r, key_mask_r, surface_r, key_max_r, tiled_pan_r;
  logic [31:0] size_act_r, key_value_act_r, key_mask_act_r, surface_act_r, key_max_act_r, tiled_pan_act_r;
  arm_state_t arm_r;
  arm_state_t arm_nxt;
  logic update_now, size_update, surf_write;

  // pipe off makes second stage transparent every cycle except size, which waits for arming
  assign update_now = vblank_start_in || !pipe_enable_in;
  assign size_update = (arm_r == arm_armed) && (vblank_start_in || !pipe_enable_in || !sprite_enable_in);
  assign surf_write = hits(reg_addr_in, off_surface_base, reg_wr_in) || flip_valid_in;

  // first stage, reserved bits never stored
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      size_r <= reg_reset;
      key_value_r <= reg_reset;
      key_mask_r <= reg_reset;
      surface_r <= reg_reset;
      key_max_r <= reg_reset;
      tiled_pan_r <= reg_reset;
    end else if (clk_en_in) begin
      if (hits(reg_addr_in, off_size, reg_wr_in)) begin
        size_r <= reg_wdata_in & size_mask;
      end
      if (hits(reg_addr_in, off_key_value, reg_wr_in)) begin
        key_value_r <= reg_wdata_in & key_value_mask;
      end
      if (hits(reg_addr_in, off_key_mask, reg_wr_in)) begin
        key_mask_r <= reg_wdata_in & key_mask_mask;
      end
      // a register write wins over a flip in the same cycle
      if (hits(reg_addr_in, off_surface_base, reg_wr_in)) begin
        surface_r <= reg_wdata_in & surface_mask;
      end else if (flip_valid_in) begin
        surface_r <= flip_surface_in & surface_mask;
      end
      if (hits(reg_addr_in, off_key_max, reg_wr_in)) begin
        key_max_r <= reg_wdata_in & key_max_mask;
      end
      if (hits(reg_addr_in, off_tiled_pan, reg_wr_in)) begin
        tiled_pan_r <= reg_wdata_in & tiled_pan_mask;
      end
    end
  end

  // arm flag: a fresh arm in the transfer cycle survives
  always_comb begin
    arm_nxt = arm_r;
    case (arm_r)
      arm_idle: begin
        if (surf_write) begin
          arm_nxt = arm_armed;
        end
      end
      arm_armed: begin
        if (size_update && !surf_write) begin
          arm_nxt = arm_idle;
        end
      end
      default: begin
        arm_nxt = arm_idle;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      arm_r <= arm_idle;
    end else if (clk_en_in) begin
      arm_r <= arm_nxt;
    end
  end

  // second stage drives the plane
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      key_value_act_r <= reg_reset;
      key_mask_act_r <= reg_reset;
      surface_act_r <= reg_reset;
      key_max_act_r <= reg_reset;
      tiled_pan_act_r <= reg_reset;
    end else if (clk_en_in && update_now) begin
      key_value_act_r <= key_value_r;
      key_mask_act_r <= key_mask_r;
      surface_act_r <= surface_r;
      key_max_act_r <= key_max_r;
      tiled_pan_act_r <= tiled_pan_r;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      size_act_r <= reg_reset;
    end else if (clk_en_in && size_update) begin
      size_act_r <= size_r;
    end
  end

  // readback of first stage
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= reg_reset;
    end else if (clk_en_in) begin
      if (!reg_rd_in) begin
        reg_rdata_out <= reg_reset;
      end else begin
        case (reg_addr_in)
          off_size: reg_rdata_out <= size_r;
          off_key_value: reg_rdata_out <= key_value_r;
          off_key_mask: reg_rdata_out <= key_mask_r;
          off_surface_base: reg_rdata_out <= surface_r;
          off_key_max: reg_rdata_out <= key_max_r;
          off_tiled_pan: reg_rdata_out <= tiled_pan_r;
          default: reg_rdata_out <= reg_reset;
        endcase
      end
    end
  end

  // geometry and panning outputs
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      height_lines_out <= '0;
      width_pixels_out <= '0;
      surface_addr_out <= '0;
      pan_linear_out <= '0;
      pan_y_out <= '0;
      pan_x_out <= '0;
      pan_lower_right_out <= 1'b0;
      size_armed_out <= 1'b0;
    end else if (clk_en_in) begin
      // fields are minus-one coded; outputs give true counts, wrapping at 4096
      height_lines_out <= size_act_r[height_lsb +: 12] + 12'h001;
      width_pixels_out <= size_act_r[width_lsb +: 12] + 12'h001;
      surface_addr_out <= surface_act_r;
      size_armed_out <= (arm_r == arm_armed);
      // tiled surface ignores linear offset and vice versa
      pan_linear_out <= tiled_surface_in ? 32'h00000000 : linear_pan_in;
      pan_y_out <= tiled_surface_in ? tiled_pan_act_r[height_lsb +: 12] : 12'h000;
      pan_x_out <= tiled_surface_in ? tiled_pan_act_r[width_lsb +: 12] : 12'h000;
      pan_lower_right_out <= tiled_surface_in && rotate_180_in;
    end
  end

  logic src_hit, dst_hit;
  logic [2:0] chan_ok;
  logic [23:0] dst_diff;

  // source key: enabled channels range-checked between value and max
  always_comb begin
    chan_ok[2] = !key_mask_act_r[src_en_lsb + 2] ||
      chan_in_range(src_pixel_in[chan_hi_lsb +: 8], key_value_act_r[chan_hi_lsb +: 8],
                    key_max_act_r[chan_hi_lsb +: 8]);
    chan_ok[1] = !key_mask_act_r[src_en_lsb + 1] ||
      chan_in_range(src_pixel_in[chan_mid_lsb +: 8], key_value_act_r[chan_mid_lsb +: 8],
                    key_max_act_r[chan_mid_lsb +: 8]);
    chan_ok[0] = !key_mask_act_r[src_en_lsb] ||
      chan_in_range(src_pixel_in[chan_lo_lsb +: 8], key_value_act_r[chan_lo_lsb +: 8],
                    key_max_act_r[chan_lo_lsb +: 8]);
    src_hit = key_src_enable_in && (&chan_ok);
    // destination key: mismatches under a zero mask bit ignored
    dst_diff = (dst_pixel_in ^ key_value_act_r[23:0]) & key_mask_act_r[23:0];
    dst_hit = key_dst_enable_in && (dst_diff == 24'h000000);
  end

  // keying off means no hit whatever the key value holds
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      key_hit_out <= 1'b0;
    end else if (clk_en_in) begin
      key_hit_out <= src_hit || dst_hit;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence surf_arm_s;
    clk_en_in && surf_write;
  endsequence

  sequence size_take_s;
    clk_en_in && size_update;
  endsequence

  sequence src_only_s;
    clk_en_in && key_src_enable_in && !key_dst_enable_in;
  endsequence

  // double buffering: copy on update, hold otherwise
  vblank_copy_a: assert property (clk_en_in && update_now |=> key_value_act_r == $past(key_value_r)
    && tiled_pan_act_r == $past(tiled_pan_r)) else $error("active key stage not loaded");
  hold_copy_a: assert property (clk_en_in && !update_now |=> $stable(surface_act_r))
    else $error("surface active changed without update");
  key_copy_a: assert property (clk_en_in && update_now |=> key_mask_act_r == $past(key_mask_r)
    && key_max_act_r == $past(key_max_r)) else $error("key mask or max not loaded");
  surf_copy_a: assert property (clk_en_in && update_now |=> surface_act_r == $past(surface_r))
    else $error("surface active not loaded");
  key_hold_a: assert property (clk_en_in && !update_now |=> $stable(key_value_act_r) && $stable(key_mask_act_r))
    else $error("key active changed without update");
  pan_hold_a: assert property (clk_en_in && !update_now |=> $stable(tiled_pan_act_r) && $stable(key_max_act_r))
    else $error("pan or max active changed without update");
  // enable low must freeze every stage, flag and output
  freeze_a: assert property (!clk_en_in |=> $stable(size_r) && $stable(surface_r) && $stable(arm_r)
    && $stable(size_act_r) && $stable(reg_rdata_out) && $stable(key_hit_out))
    else $error("state moved while clock enable low");

  // arming of the size register
  size_arm_a: assert property (surf_arm_s |=> arm_r == arm_armed)
    else $error("surface write did not arm");
  size_wait_a: assert property (arm_r == arm_idle |=> $stable(size_act_r))
    else $error("size moved while not armed");
  size_hold_a: assert property (clk_en_in && !size_update |=> $stable(size_act_r))
    else $error("size moved without transfer");
  sprite_off_a: assert property (clk_en_in && arm_r == arm_armed && !sprite_enable_in
    |=> size_act_r == $past(size_r)) else $error("sprite off did not take armed size");
  arm_out_a: assert property (clk_en_in |=> size_armed_out == ($past(arm_r) == arm_armed))
    else $error("armed output disagrees with flag");
  size_take_a: assert property (size_take_s ##0 !surf_write
    |=> arm_r == arm_idle && size_act_r == $past(size_r)) else $error("armed size not transferred");
  arm_keep_a: assert property (size_take_s ##0 surf_write |=> arm_r == arm_armed)
    else $error("fresh arm lost in transfer cycle");

  // geometry and surface
  height_count_a: assert property (clk_en_in
    |=> height_lines_out == 12'($past(size_act_r[27:16]) + 12'h001)) else $error("height not minus one coded");
  width_count_a: assert property (clk_en_in
    |=> width_pixels_out == 12'($past(size_act_r[11:0]) + 12'h001)) else $error("width not minus one coded");
  surf_low_a: assert property (surface_r[11:0] == 12'h000)
    else $error("surface low bits not zero");
  surf_out_a: assert property (clk_en_in |=> surface_addr_out == $past(surface_act_r))
    else $error("surface output not active stage");
  surf_wr_a: assert property (clk_en_in && hits(reg_addr_in, off_surface_base, reg_wr_in)
    |=> surface_r == ($past(reg_wdata_in) & surface_mask)) else $error("surface write not stored");
  flip_load_a: assert property (clk_en_in && flip_valid_in && !hits(reg_addr_in, off_surface_base, reg_wr_in)
    |=> surface_r == ($past(flip_surface_in) & surface_mask)) else $error("flip surface not stored");

  // panning selection
  linear_pan_a: assert property (clk_en_in && !tiled_surface_in |=> pan_x_out == 12'h000 && pan_y_out == 12'h000)
    else $error("tiled offset used on linear surface");
  linear_sel_a: assert property (clk_en_in && !tiled_surface_in |=> pan_linear_out == $past(linear_pan_in))
    else $error("linear offset not passed");
  tiled_pan_a: assert property (clk_en_in && tiled_surface_in
    |=> pan_y_out == $past(tiled_pan_act_r[27:16]) && pan_x_out == $past(tiled_pan_act_r[11:0]))
    else $error("tiled offset fields wrong");
  corner_a: assert property (clk_en_in |=> pan_lower_right_out == ($past(tiled_surface_in) && $past(rotate_180_in)))
    else $error("rotation corner flag wrong");

  // keying
  key_off_a: assert property (clk_en_in && !key_src_enable_in && !key_dst_enable_in |=> !key_hit_out)
    else $error("key hit while keying disabled");
  dst_match_a: assert property (clk_en_in && key_dst_enable_in
    && ((dst_pixel_in ^ key_value_act_r[23:0]) & key_mask_act_r[23:0]) == 24'h000000 |=> key_hit_out)
    else $error("masked destination match missed");
  src_max_a: assert property (src_only_s ##0 (key_mask_act_r[26] && src_pixel_in[23:16] > key_max_act_r[23:16])
    |=> !key_hit_out) else $error("source hit above channel maximum");
  src_min_a: assert property (src_only_s ##0 (key_mask_act_r[24] && src_pixel_in[7:0] < key_value_act_r[7:0])
    |=> !key_hit_out) else $error("source hit below channel minimum");

  // readback
  read_back_a: assert property (clk_en_in && reg_rd_in && reg_addr_in == off_key_mask
    |=> reg_rdata_out == $past(key_mask_r)) else $error("readback not first stage");
  size_rd_a: assert property (clk_en_in && reg_rd_in && reg_addr_in == off_size
    |=> reg_rdata_out == $past(size_r)) else $error("size readback not first stage");
  size_wr_a: assert property (clk_en_in && hits(reg_addr_in, off_size, reg_wr_in)
    |=> size_r == ($past(reg_wdata_in) & size_mask)) else $error("size reserved bits stored");
  tiled_wr_a: assert property (clk_en_in && hits(reg_addr_in, off_tiled_pan, reg_wr_in)
    |=> tiled_pan_r == ($past(reg_wdata_in) & tiled_pan_mask)) else $error("tiled reserved bits stored");
  rd_idle_a: assert property (clk_en_in && !reg_rd_in |=> reg_rdata_out == 32'h00000000)
    else $error("read data not cleared without read");

endmodule // sprite_plane_geometry_key_regs
`default_nettype wire

// File: sim/sprite_plane_geometry_key_regs_tb_top.sv
// self-checking bench for the sprite geometry and colour-key register bank
// assumes the bank alone, driven at its ports from one 125 MHz clock
`default_nettype none
module sprite_plane_geometry_key_regs_tb_top
  import sprite_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, reset_in = 1'b1, clk_en_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic flip_valid_in = 1'b0, vblank_start_in = 1'b0, pipe_enable_in = 1'b1, sprite_enable_in = 1'b1;
  logic key_src_enable_in = 1'b0, key_dst_enable_in = 1'b0, tiled_surface_in = 1'b0, rotate_180_in = 1'b0;
  logic [19:0] reg_addr_in = 20'h00000;
  logic [31:0] reg_wdata_in = 32'h0, flip_surface_in = 32'h0, linear_pan_in = 32'h0;
  logic [23:0] src_pixel_in = 24'h0, dst_pixel_in = 24'h0;
  logic [31:0] reg_rdata_out, surface_addr_out, pan_linear_out;
  logic [11:0] height_lines_out, width_pixels_out, pan_y_out, pan_x_out;
  logic pan_lower_right_out, key_hit_out, size_armed_out;
  int n_errors = 0;
  int checked = 0;
  localparam logic [19:0] offs [6] = '{off_size, off_key_value, off_key_mask, off_surface_base, off_key_max,
    off_tiled_pan};
  localparam logic [31:0] masks [6] = '{size_mask, key_value_mask, key_mask_mask, surface_mask, key_max_mask,
    tiled_pan_mask};

  always #4 clk_in = ~clk_in;

  sprite_plane_geometry_key_regs uut (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .flip_valid_in(flip_valid_in), .flip_surface_in(flip_surface_in),
    .vblank_start_in(vblank_start_in), .pipe_enable_in(pipe_enable_in), .sprite_enable_in(sprite_enable_in),
    .key_src_enable_in(key_src_enable_in), .key_dst_enable_in(key_dst_enable_in),
    .tiled_surface_in(tiled_surface_in), .rotate_180_in(rotate_180_in), .linear_pan_in(linear_pan_in),
    .src_pixel_in(src_pixel_in), .dst_pixel_in(dst_pixel_in), .height_lines_out(height_lines_out),
    .width_pixels_out(width_pixels_out), .surface_addr_out(surface_addr_out), .pan_linear_out(pan_linear_out),
    .pan_y_out(pan_y_out), .pan_x_out(pan_x_out), .pan_lower_right_out(pan_lower_right_out),
    .key_hit_out(key_hit_out), .size_armed_out(size_armed_out));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // strobe dropped at the taking edge, so back-to-back calls leave one idle cycle
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp);
  endtask
  task automatic vblank();
    @(posedge clk_in);
    vblank_start_in <= 1'b1;
    @(posedge clk_in);
    vblank_start_in <= 1'b0;
    tick(2);
  endtask
  task automatic pix(input logic [23:0] s, input logic [23:0] d, input logic exp);
    @(posedge clk_in);
    src_pixel_in <= s;
    dst_pixel_in <= d;
    tick(2);
    chk({31'h0, key_hit_out}, {31'h0, exp});
  endtask

  task automatic test_reset();
    for (int i = 0; i < 6; i++) rd(offs[i], reg_reset);
    chk(surface_addr_out, 32'h0);
    chk({31'h0, size_armed_out}, 32'h0);
    $display("test reset done");
  endtask
  task automatic test_fields();
    for (int i = 0; i < 6; i++) begin
      wr(offs[i], 32'hffffffff);
      rd(offs[i], masks[i]);
    end
    rd(20'h72180, 32'h0);
    chk(surface_addr_out, 32'h0);
    vblank();
    chk(surface_addr_out, 32'hfffff000);
    $display("test fields done");
  endtask
  task automatic test_size();
    wr(off_size, 32'h00ef013f);
    vblank();
    chk({8'h0, height_lines_out, width_pixels_out}, 32'h0);
    wr(off_surface_base, 32'h12345000);
    tick(2);
    chk({31'h0, size_armed_out}, 32'h1);
    vblank();
    chk({8'h0, height_lines_out, width_pixels_out}, 32'h000f0140);
    chk({31'h0, size_armed_out}, 32'h0);
    wr(off_size, 32'h00010003);
    wr(off_surface_base, 32'h00002000);
    sprite_enable_in <= 1'b0;
    tick(3);
    chk({8'h0, height_lines_out, width_pixels_out}, 32'h00002004);
    @(posedge clk_in);
    sprite_enable_in <= 1'b1;
    flip_valid_in <= 1'b1;
    flip_surface_in <= 32'h0abcd000;
    @(posedge clk_in);
    flip_valid_in <= 1'b0;
    tick(1);
    chk({31'h0, size_armed_out}, 32'h1);
    vblank();
    chk(surface_addr_out, 32'h0abcd000);
    $display("test size done");
  endtask
  task automatic test_pan();
    linear_pan_in <= 32'h00001234;
    wr(off_tiled_pan, 32'h00450067);
    vblank();
    chk(pan_linear_out, 32'h00001234);
    chk({8'h0, pan_y_out, pan_x_out}, 32'h0);
    @(posedge clk_in);
    tiled_surface_in <= 1'b1;
    rotate_180_in <= 1'b1;
    pipe_enable_in <= 1'b0;
    tick(2);
    chk(pan_linear_out, 32'h0);
    chk({8'h0, pan_y_out, pan_x_out}, 32'h00045067);
    chk({31'h0, pan_lower_right_out}, 32'h1);
    wr(off_tiled_pan, 32'h0fff0001);
    tick(2);
    chk({8'h0, pan_y_out, pan_x_out}, 32'h00fff001);
    @(posedge clk_in);
    pipe_enable_in <= 1'b1;
    tiled_surface_in <= 1'b0;
    rotate_180_in <= 1'b0;
    $display("test pan done");
  endtask
  task automatic test_key();
    wr(off_key_value, 32'h00102030);
    wr(off_key_mask, 32'h00ff00f0);
    vblank();
    pix(24'h0, 24'h10ee3f, 1'b0);
    key_dst_enable_in <= 1'b1;
    pix(24'h0, 24'h10ee3f, 1'b1);
    pix(24'h0, 24'h11ee30, 1'b0);
    pix(24'h0, 24'h102040, 1'b0);
    // dst mask bytes zeroed while source keying is used
    wr(off_key_mask, 32'h05000000);
    wr(off_key_max, 32'h00304050);
    vblank();
    key_dst_enable_in <= 1'b0;
    key_src_enable_in <= 1'b1;
    pix(24'h10ff30, 24'h0, 1'b1);
    pix(24'h300050, 24'h0, 1'b1);
    pix(24'h31ff40, 24'h0, 1'b0);
    pix(24'h0f0040, 24'h0, 1'b0);
    pix(24'h20ff51, 24'h0, 1'b0);
    key_src_enable_in <= 1'b0;
    $display("test key done");
  endtask
  // a write while the enable is low must not land
  task automatic test_enable();
    @(posedge clk_in);
    clk_en_in <= 1'b0;
    wr(off_key_max, 32'h00aabbcc);
    @(posedge clk_in);
    clk_en_in <= 1'b1;
    rd(off_key_max, 32'h00304050);
    $display("test enable done");
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    test_reset();
    test_fields();
    test_size();
    test_pan();
    test_key();
    test_enable();
    close_out();
  end
  // whole run is well under a thousand cycles; this is a generous cap
  initial begin
    #200us;
    n_errors++;
    close_out();
  end
endmodule // sprite_plane_geometry_key_regs_tb_top
`default_nettype wire
